// ### bench/clear_pin_model.sv
`timescale 1ns/1ps
module clear_pin_model (
	input wire logic hold_low,
	output logic master_clear_pin_n
);
	// Pulled up whenever nobody holds it low
	assign master_clear_pin_n = hold_low ? 1'b0 : 1'b1;
endmodule

// ### bench/reset_sequencer_test.sv
`timescale 1ns/1ps
module reset_sequencer_test;
	import reset_seq_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq, core_in_reset, pin_n;
	logic pos, undef;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, rd;
	logic hold_low = 1'b0, dis = 1'b0, wdt = 1'b0, sleep_cmd = 1'b0, step = 1'b0;
	logic [7:0] wake = 8'h00;
	osc_mode_t osc_mode = OSC_CRYSTAL;
	core_regs_t regs;
	int n_mismatch = 0;
	int tests_run = 0;

	always #5 aclk = ~aclk;

	clear_pin_model pin (.hold_low(hold_low), .master_clear_pin_n(pin_n));

	reset_sequencer #(.POWERUP_DELAY_TIMER_COUNT(20)) dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.master_clear_pin_n(pin_n), .osc_mode(osc_mode), .powerup_delay_disable(dis),
		.watchdog_timeout(wdt), .irq_wake_flags(wake), .sleep_cmd(sleep_cmd),
		.instr_step(step), .core_in_reset(core_in_reset), .core_regs(regs),
		.power_on_seen(pos), .user_state_undefined(undef), .irq(irq)
	);

	task automatic close_out;
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge aclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge aclk); while (!(awready && wready));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b0;
	endtask

	task automatic rdr(input logic [11:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rd = rdata;
		rready <= 1'b0;
	endtask

	task automatic rc(input logic [11:0] a, input logic [31:0] exp, input string what);
		rdr(a);
		chk(what, rd, exp);
	endtask

	task automatic run_wait(output int n);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (core_in_reset === 1'b1);
	endtask

	task automatic power_on(input osc_mode_t m, input logic d, input int lo, input int hi);
		int n;
		aresetn <= 1'b0;
		osc_mode <= m;
		dis <= d;
		cyc(5);
		chk("user state undefined", 32'(undef), 32'h1);
		aresetn <= 1'b1;
		run_wait(n);
		chk("startup length in range", 32'(n >= lo && n <= hi), 32'h1);
		chk("power-on seen", 32'(pos), 32'h1);
		chk("user state settled", 32'(undef), 32'h0);
	endtask

	task automatic held_pin;
		int n;
		hold_low <= 1'b1;
		aresetn <= 1'b0;
		osc_mode <= OSC_RC;
		dis <= 1'b0;
		cyc(5);
		aresetn <= 1'b1;
		cyc(100);
		chk("held by pin", 32'(core_in_reset), 32'h1);
		hold_low <= 1'b0;
		run_wait(n);
		chk("start after release", 32'(n <= 6), 32'h1);
	endtask

	task automatic por_values;
		rc(12'h00c, 32'h18, "status");
		rc(12'h238, 32'h0, "power control");
		rc(12'h204, 32'hff, "option");
		rc(12'h214, 32'h1f, "dir a");
		chk("pc", 32'(regs.pc), 32'h0);
		chk("pc latch", 32'(regs.pc_high_latch), 32'h0);
		chk("irq control", 32'(regs.irq_control_reg), 32'h0);
		rdr(12'hffc);
		chk("unmapped resp", 32'(rresp), 32'(RESP_SLVERR));
		chk("unmapped data", rd, 32'h0);
		wr(12'h238, 32'h2);
		rc(12'h238, 32'h2, "flag written");
	endtask

	task automatic wdt_reset;
		int n;
		wr(12'h204, 32'h0);
		step <= 1'b1;
		cyc(3);
		step <= 1'b0;
		wdt <= 1'b1;
		cyc(1);
		wdt <= 1'b0;
		run_wait(n);
		chk("pc after wdt", 32'(regs.pc), 32'h0);
		rc(12'h00c, 32'h08, "status wdt");
		rc(12'h238, 32'h2, "flag kept");
		chk("power-on seen wdt", 32'(pos), 32'h0);
		rc(12'h204, 32'hff, "option reload");
	endtask

	task automatic events;
		rc(12'h240, 32'h05, "events");
		chk("irq masked", 32'(irq), 32'h0);
		wr(12'h244, 32'h04);
		chk("irq raised", 32'(irq), 32'h1);
		wr(12'h240, 32'h05);
		chk("irq cleared", 32'(irq), 32'h0);
		rc(12'h240, 32'h0, "events cleared");
	endtask

	task automatic pin_resets;
		int n;
		step <= 1'b1;
		cyc(1);
		step <= 1'b0;
		hold_low <= 1'b1;
		cyc(4);
		hold_low <= 1'b0;
		run_wait(n);
		chk("pc after pin", 32'(regs.pc), 32'h0);
		rc(12'h00c, 32'h08, "status pin run");
		sleep_cmd <= 1'b1;
		cyc(1);
		sleep_cmd <= 1'b0;
		cyc(2);
		hold_low <= 1'b1;
		cyc(4);
		hold_low <= 1'b0;
		run_wait(n);
		rc(12'h00c, 32'h10, "status pin sleep");
		rc(12'h238, 32'h2, "flag kept pin");
	endtask

	task automatic wakes;
		int n;
		wr(12'h204, 32'h0);
		step <= 1'b1;
		cyc(2);
		step <= 1'b0;
		sleep_cmd <= 1'b1;
		cyc(1);
		sleep_cmd <= 1'b0;
		cyc(2);
		wdt <= 1'b1;
		cyc(1);
		wdt <= 1'b0;
		run_wait(n);
		chk("wake delay", 32'(n >= 1020 && n <= 1035), 32'h1);
		chk("pc wdt wake", 32'(regs.pc), 32'h3);
		rc(12'h00c, 32'h00, "status wdt wake");
		rc(12'h204, 32'h0, "option kept wake");
		wr(12'h02c, 32'h80);
		step <= 1'b1;
		cyc(2);
		step <= 1'b0;
		sleep_cmd <= 1'b1;
		cyc(1);
		sleep_cmd <= 1'b0;
		cyc(2);
		wake <= 8'h01;
		cyc(1);
		wake <= 8'h00;
		run_wait(n);
		chk("pc irq wake", 32'(regs.pc), 32'h6);
		rc(12'h00c, 32'h10, "status irq wake");
		step <= 1'b1;
		cyc(1);
		step <= 1'b0;
		cyc(1);
		chk("vector", 32'(regs.pc), 32'(PC_VECTOR));
		chk("irq control wake", 32'(regs.irq_control_reg), 32'h01);
		rc(12'h240, 32'h1a, "events wake");
	endtask

	initial begin
		power_on(OSC_RC, 1'b1, 1, 5);
		power_on(OSC_RC, 1'b0, 18, 28);
		power_on(OSC_CRYSTAL, 1'b1, 1020, 1035);
		power_on(OSC_LOW_POWER, 1'b1, 1020, 1035);
		power_on(OSC_HIGH_SPEED, 1'b1, 1020, 1035);
		held_pin();
		power_on(OSC_CRYSTAL, 1'b0, 1040, 1055);
		por_values();
		wdt_reset();
		events();
		pin_resets();
		wakes();
		close_out();
	end

	initial begin
		cyc(50000);
		n_mismatch++;
		close_out();
	end
endmodule

// ### rtl/reset_seq_pkg.sv
package reset_seq_pkg;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_START = 3'b000,
		ST_POWERUP_DELAY_TIMER = 3'b001,
		ST_OST = 3'b010,
		ST_HOLD = 3'b011,
		ST_RUN = 3'b100,
		ST_SLEEP = 3'b101
	} seq_state_t;

	// Oscillator configuration
	typedef enum logic [1:0] {
		OSC_LOW_POWER = 2'b00,
		OSC_CRYSTAL = 2'b01,
		OSC_HIGH_SPEED = 2'b10,
		OSC_RC = 2'b11
	} osc_mode_t;

	// Register indices; byte address is four times the index
	localparam int ADDR_W = 12;
	localparam logic [9:0] IDX_STATUS = 10'h003;
	localparam logic [9:0] IDX_IRQ_CONTROL = 10'h00b;
	localparam logic [9:0] IDX_OPTION = 10'h081;
	localparam logic [9:0] IDX_DIR_A = 10'h085;
	localparam logic [9:0] IDX_DIR_B = 10'h086;
	localparam logic [9:0] IDX_DIR_C = 10'h087;
	localparam logic [9:0] IDX_POWER_CONTROL = 10'h08e;
	localparam logic [9:0] IDX_EVT_STATUS = 10'h090;
	localparam logic [9:0] IDX_EVT_MASK = 10'h091;
	localparam logic [9:0] IDX_SEQ_VIEW = 10'h092;

	// Field positions and reset values
	localparam int TO_BIT = 4;
	localparam int PD_BIT = 3;
	localparam int POR_FLAG_BIT = 1;
	localparam int GIE_BIT = 7;
	localparam logic [7:0] STATUS_POR = 8'h18;
	localparam logic [7:0] OPTION_RST = 8'hff;
	localparam logic [7:0] DIR8_RST = 8'hff;
	localparam logic [4:0] DIR5_RST = 5'h1f;
	localparam logic [12:0] PC_RESET = 13'h0000;
	localparam logic [12:0] PC_VECTOR = 13'h0004;
	localparam logic [4:0] PC_HIGH_LATCH_RST = 5'h00;

	// Event bits
	localparam int EV_N = 5;
	localparam int EV_POR = 0;
	localparam int EV_MASTER_CLEAR_PIN = 1;
	localparam int EV_WDT_RST = 2;
	localparam int EV_WDT_WAKE = 3;
	localparam int EV_IRQ_WAKE = 4;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int POWERUP_DELAY_TIMER_TIME_MS = 72;
	localparam int POWERUP_DELAY_TIMER_CYCLES = POWERUP_DELAY_TIMER_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int OST_TOSC = 1024;
	localparam int OST_CYCLES = OST_TOSC;
	localparam int CNT_W = 24;

	// Core-facing register view
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] irq_control_reg;
		logic [7:0] option;
		logic [4:0] port_a_direction;
		logic [7:0] port_b_direction;
		logic [7:0] port_c_direction;
		logic [12:0] pc;
		logic [4:0] pc_high_latch;
	} core_regs_t;

endpackage

// ### rtl/reset_sequencer.sv
`timescale 1ns/1ps
// Overview of operation
// - Power-on flag bit 1 is cleared by power-on, written by software, kept by other resets.
// - A zero flag at a later reset means a power-on happened.
// - Crystal modes: 72 ms plus 1024 periods, 1024 alone, 1024 on wake.
// - RC mode: 72 ms only when enabled, no delay otherwise or on wake.
// - Power-on: flag 0, timeout and sleep bits both 1.
// - Watchdog reset clears timeout; watchdog wake clears timeout and sleep.
// - Pin reset keeps bits in run; in sleep sets timeout, clears sleep.
// - Resets load PC 000h; wake-ups continue at PC plus one.
// - Status word takes its documented value for each reset cause.
// - Interrupt wake with global enable runs PC+1, then vector 0004h.
// - Resets clear PC low byte and high latch; wake keeps latch.
// - Interrupt control clears on resets, bit 0 only at power-on; wake only sets.
// - Unimplemented bits read as zero.
// - Device stays in reset while the power-up timer runs.
// - Timeouts run from power-on; pin release then starts at once.
module reset_sequencer
	import reset_seq_pkg::*;
#(
	parameter int POWERUP_DELAY_TIMER_COUNT = reset_seq_pkg::POWERUP_DELAY_TIMER_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [reset_seq_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [reset_seq_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic master_clear_pin_n,
	input wire reset_seq_pkg::osc_mode_t osc_mode,
	input wire logic powerup_delay_disable,
	input wire logic watchdog_timeout,
	input wire logic [7:0] irq_wake_flags,
	input wire logic sleep_cmd,
	input wire logic instr_step,
	output logic core_in_reset,
	output reset_seq_pkg::core_regs_t core_regs,
	output logic power_on_seen,
	output logic user_state_undefined,
	output logic irq
);
	import reset_seq_pkg::*;

	typedef struct packed {
		seq_state_t st;
		logic [CNT_W-1:0] cnt;
		logic ost_next;
		logic m1;
		logic m2;
		core_regs_t r;
		logic pflag;
		logic vec_pend;
		logic undef;
		logic [EV_N-1:0] evt;
		logic [EV_N-1:0] mask;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} state_t;

	state_t s_r;
	state_t s_nxt;
	logic wr_go;
	logic rd_go;
	logic master_clear_pin_hi;
	logic crystal;

	function automatic logic [9:0] reg_index(input logic [ADDR_W-1:0] a);
		return a[11:2];
	endfunction

	// Register values common to every reset
	function automatic core_regs_t reset_regs(input core_regs_t c);
		core_regs_t o;
		o = c;
		o.pc = PC_RESET;
		o.pc_high_latch = PC_HIGH_LATCH_RST;
		o.irq_control_reg = {7'h00, c.irq_control_reg[0]};
		o.option = OPTION_RST;
		o.port_a_direction = DIR5_RST;
		o.port_b_direction = DIR8_RST;
		o.port_c_direction = DIR8_RST;
		o.status[7:5] = 3'h0;
		return o;
	endfunction

	assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_r.bvalid;
	assign rd_go = s_axi_arvalid && !s_r.rvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = rd_go;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rresp = s_r.rresp;
	assign s_axi_rdata = s_r.rdata;
	assign master_clear_pin_hi = s_r.m2;
	assign crystal = (osc_mode != OSC_RC);
	assign core_regs = s_r.r;
	assign core_in_reset = (s_r.st != ST_RUN) && (s_r.st != ST_SLEEP);
	assign power_on_seen = !s_r.pflag;
	assign user_state_undefined = s_r.undef;
	assign irq = |(s_r.evt & s_r.mask);

	always_comb begin
		logic [9:0] widx;
		logic [9:0] ridx;
		widx = reg_index(s_axi_awaddr);
		ridx = reg_index(s_axi_araddr);
		s_nxt = s_r;
		s_nxt.m1 = master_clear_pin_n;
		s_nxt.m2 = s_r.m1;
		s_nxt.undef = 1'b0;

		// Register writes
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (wr_go) begin
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = RESP_OKAY;
			if (!s_axi_wstrb[0]) begin
				s_nxt.bresp = RESP_OKAY;
			end else if (widx == IDX_STATUS) begin
				s_nxt.r.status[7:5] = s_axi_wdata[7:5];
				s_nxt.r.status[2:0] = s_axi_wdata[2:0];
			end else if (widx == IDX_POWER_CONTROL) begin
				s_nxt.pflag = s_axi_wdata[POR_FLAG_BIT];
			end else if (widx == IDX_IRQ_CONTROL) begin
				s_nxt.r.irq_control_reg = s_axi_wdata[7:0];
			end else if (widx == IDX_OPTION) begin
				s_nxt.r.option = s_axi_wdata[7:0];
			end else if (widx == IDX_DIR_A) begin
				s_nxt.r.port_a_direction = s_axi_wdata[4:0];
			end else if (widx == IDX_DIR_B) begin
				s_nxt.r.port_b_direction = s_axi_wdata[7:0];
			end else if (widx == IDX_DIR_C) begin
				s_nxt.r.port_c_direction = s_axi_wdata[7:0];
			end else if (widx == IDX_EVT_STATUS) begin
				s_nxt.evt = s_r.evt & ~s_axi_wdata[EV_N-1:0];
			end else if (widx == IDX_EVT_MASK) begin
				s_nxt.mask = s_axi_wdata[EV_N-1:0];
			end else begin
				s_nxt.bresp = RESP_SLVERR;
			end
		end

		// Register reads
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (rd_go) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = RESP_OKAY;
			s_nxt.rdata = 32'h0000_0000;
			if (ridx == IDX_STATUS) begin
				s_nxt.rdata[7:0] = s_r.r.status;
			end else if (ridx == IDX_POWER_CONTROL) begin
				s_nxt.rdata[POR_FLAG_BIT] = s_r.pflag;
			end else if (ridx == IDX_IRQ_CONTROL) begin
				s_nxt.rdata[7:0] = s_r.r.irq_control_reg;
			end else if (ridx == IDX_OPTION) begin
				s_nxt.rdata[7:0] = s_r.r.option;
			end else if (ridx == IDX_DIR_A) begin
				s_nxt.rdata[4:0] = s_r.r.port_a_direction;
			end else if (ridx == IDX_DIR_B) begin
				s_nxt.rdata[7:0] = s_r.r.port_b_direction;
			end else if (ridx == IDX_DIR_C) begin
				s_nxt.rdata[7:0] = s_r.r.port_c_direction;
			end else if (ridx == IDX_EVT_STATUS) begin
				s_nxt.rdata[EV_N-1:0] = s_r.evt;
			end else if (ridx == IDX_EVT_MASK) begin
				s_nxt.rdata[EV_N-1:0] = s_r.mask;
			end else if (ridx == IDX_SEQ_VIEW) begin
				s_nxt.rdata[20:0] = {s_r.st, s_r.r.pc_high_latch, s_r.r.pc};
			end else begin
				s_nxt.rresp = RESP_SLVERR;
			end
		end

		// Reset and wake sequencing; hardware sets win over software
		case (s_r.st)
			ST_START: begin
				s_nxt.cnt = '0;
				s_nxt.ost_next = crystal;
				if (!powerup_delay_disable) begin
					s_nxt.st = ST_POWERUP_DELAY_TIMER;
				end else if (crystal) begin
					s_nxt.st = ST_OST;
				end else begin
					s_nxt.st = ST_HOLD;
				end
			end
			ST_POWERUP_DELAY_TIMER: begin
				s_nxt.cnt = s_r.cnt + 1'b1;
				if (s_r.cnt == CNT_W'(POWERUP_DELAY_TIMER_COUNT - 1)) begin
					s_nxt.cnt = '0;
					s_nxt.st = s_r.ost_next ? ST_OST : ST_HOLD;
				end
			end
			ST_OST: begin
				s_nxt.cnt = s_r.cnt + 1'b1;
				if (s_r.cnt == CNT_W'(OST_CYCLES - 1)) begin
					s_nxt.cnt = '0;
					s_nxt.st = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (master_clear_pin_hi) begin
					s_nxt.st = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!master_clear_pin_hi) begin
					s_nxt.r = reset_regs(s_r.r);
					s_nxt.vec_pend = 1'b0;
					s_nxt.evt[EV_MASTER_CLEAR_PIN] = 1'b1;
					s_nxt.st = ST_HOLD;
				end else if (watchdog_timeout) begin
					s_nxt.r = reset_regs(s_r.r);
					s_nxt.r.status[TO_BIT] = 1'b0;
					s_nxt.vec_pend = 1'b0;
					s_nxt.evt[EV_WDT_RST] = 1'b1;
					s_nxt.st = ST_HOLD;
				end else if (sleep_cmd) begin
					s_nxt.r.status[TO_BIT] = 1'b1;
					s_nxt.r.status[PD_BIT] = 1'b0;
					s_nxt.st = ST_SLEEP;
				end else if (instr_step) begin
					if (s_r.vec_pend) begin
						s_nxt.r.pc = PC_VECTOR;
						s_nxt.r.irq_control_reg[GIE_BIT] = 1'b0;
						s_nxt.vec_pend = 1'b0;
					end else begin
						s_nxt.r.pc = s_r.r.pc + 1'b1;
					end
				end
			end
			ST_SLEEP: begin
				if (!master_clear_pin_hi) begin
					s_nxt.r = reset_regs(s_r.r);
					s_nxt.r.status[TO_BIT] = 1'b1;
					s_nxt.r.status[PD_BIT] = 1'b0;
					s_nxt.evt[EV_MASTER_CLEAR_PIN] = 1'b1;
					s_nxt.st = ST_HOLD;
				end else if (watchdog_timeout || (irq_wake_flags != 8'h00)) begin
					s_nxt.r.pc = s_r.r.pc + 1'b1;
					s_nxt.r.status[PD_BIT] = 1'b0;
					s_nxt.cnt = '0;
					s_nxt.st = crystal ? ST_OST : ST_RUN;
					if (watchdog_timeout) begin
						s_nxt.r.status[TO_BIT] = 1'b0;
						s_nxt.evt[EV_WDT_WAKE] = 1'b1;
					end else begin
						s_nxt.r.status[TO_BIT] = 1'b1;
						s_nxt.r.irq_control_reg = s_r.r.irq_control_reg | irq_wake_flags;
						s_nxt.vec_pend = s_r.r.irq_control_reg[GIE_BIT];
						s_nxt.evt[EV_IRQ_WAKE] = 1'b1;
					end
				end
			end
			default: begin
				s_nxt.st = ST_HOLD;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.st <= ST_START;
			s_r.m1 <= 1'b0;
			s_r.m2 <= 1'b0;
			s_r.r.status <= STATUS_POR;
			s_r.r.irq_control_reg <= 8'h00;
			s_r.r.option <= OPTION_RST;
			s_r.r.port_a_direction <= DIR5_RST;
			s_r.r.port_b_direction <= DIR8_RST;
			s_r.r.port_c_direction <= DIR8_RST;
			s_r.r.pc <= PC_RESET;
			s_r.r.pc_high_latch <= PC_HIGH_LATCH_RST;
			s_r.pflag <= 1'b0;
			s_r.undef <= 1'b1;
			s_r.evt <= 5'h01;
		end else begin
			s_r <= s_nxt;
		end
	end

	AST_PFLAG_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(aresetn) && $past(s_r.pflag)
		&& !$past(wr_go && reg_index(s_axi_awaddr) == IDX_POWER_CONTROL)
		|-> s_r.pflag)
		else $error("power-on flag lost without a write");

	AST_POR_STATUS: assert property (@(posedge aclk)
		$rose(aresetn) |-> s_r.r.status == STATUS_POR && !s_r.pflag && s_r.st == ST_START)
		else $error("power-on status word wrong");

	AST_OST_LEN: assert property (@(posedge aclk) disable iff (!aresetn)
		s_r.st == ST_OST && s_r.cnt == 24'h0003fe |=> s_r.st == ST_OST ##1 s_r.st == ST_HOLD)
		else $error("oscillator start-up not 1024 cycles");

	AST_RC_NODELAY: assert property (@(posedge aclk) disable iff (!aresetn)
		s_r.st == ST_START && osc_mode == OSC_RC && powerup_delay_disable
		|=> s_r.st == ST_HOLD)
		else $error("RC mode with timer disabled delayed");

	AST_POWERUP_DELAY_TIMER_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		s_r.st == ST_POWERUP_DELAY_TIMER |-> core_in_reset ##1 (s_r.st == ST_POWERUP_DELAY_TIMER || s_r.cnt == 24'h000000))
		else $error("core released while power-up timer ran");

	AST_MASTER_CLEAR_PIN_RELEASE: assert property (@(posedge aclk) disable iff (!aresetn)
		s_r.st == ST_HOLD && master_clear_pin_hi |=> s_r.st == ST_RUN && !core_in_reset)
		else $error("pin release did not start execution");

	AST_WDT_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
		s_r.st == ST_RUN && master_clear_pin_hi && watchdog_timeout
		|=> !s_r.r.status[TO_BIT] && s_r.r.status[PD_BIT] == $past(s_r.r.status[PD_BIT])
		&& s_r.r.pc == PC_RESET)
		else $error("watchdog reset status or PC wrong");

	AST_WAKE_PC: assert property (@(posedge aclk) disable iff (!aresetn)
		s_r.st == ST_SLEEP && master_clear_pin_hi && (watchdog_timeout || irq_wake_flags != 8'h00)
		|=> s_r.r.pc == 13'($past(s_r.r.pc) + 1'b1) && !s_r.r.status[PD_BIT]
		&& s_r.r.pc_high_latch == $past(s_r.r.pc_high_latch))
		else $error("wake-up PC or latch wrong");

	AST_MASTER_CLEAR_PIN_SLEEP: assert property (@(posedge aclk) disable iff (!aresetn)
		s_r.st == ST_SLEEP && !master_clear_pin_hi
		|=> s_r.r.status[TO_BIT] && !s_r.r.status[PD_BIT] && s_r.r.option == OPTION_RST)
		else $error("pin reset in sleep status wrong");

	COV_POR_RUN: cover property (@(posedge aclk) disable iff (!aresetn)
		s_r.st == ST_HOLD ##1 s_r.st == ST_RUN);
	COV_WDT_WAKE: cover property (@(posedge aclk) disable iff (!aresetn)
		s_r.st == ST_SLEEP && watchdog_timeout && master_clear_pin_hi);
	COV_VECTOR: cover property (@(posedge aclk) disable iff (!aresetn)
		s_r.vec_pend && instr_step && s_r.st == ST_RUN);
	COV_IRQ: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));

endmodule
